// [hw/dpac_pkg.sv]
package dpac_pkg;
	// Port mode straps, taken once after reset.
	localparam logic [1:0] PSEL_JTAG4 = 2'h0;
	localparam logic [1:0] PSEL_SWD = 2'h1;
	localparam logic [1:0] PSEL_JTAG5 = 2'h2;
	localparam logic [1:0] PSEL_OFF = 2'h3;
	// Instruction register.
	localparam int IR_LEN = 4;
	localparam logic [3:0] IR_EXTEST = 4'h0;
	localparam logic [3:0] IR_IDCODE = 4'h1;
	localparam logic [3:0] IR_SAMPLE = 4'h2;
	localparam logic [3:0] IR_DEVRST = 4'h8;
	localparam logic [3:0] IR_BYPASS = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	// Identity code value is arbitrary.
	localparam logic [31:0] ID_CODE = 32'h1234_5001;
	// Link timing.
	localparam int MCLK_HZ = 40_000_000;
	localparam int TCK_MAX_HZ = 12_000_000;
	localparam int TCK_MIN_CYC = (MCLK_HZ + TCK_MAX_HZ - 1) / TCK_MAX_HZ;
	// Trace framing.
	localparam int TRACE_DIV = 4;
	localparam logic [3:0] PAR_STEPS = 4'h2;
	localparam logic [3:0] SER_STEPS = 4'hA;
	// Pin synchroniser reset levels: trst_n, tdi, tms, tck.
	localparam logic [3:0] PIN_RST = 4'hE;
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010, TAP_CAP_DR = 4'b0011,
		TAP_SH_DR = 4'b0100, TAP_EX1_DR = 4'b0101, TAP_PA_DR = 4'b0110, TAP_EX2_DR = 4'b0111,
		TAP_UPD_DR = 4'b1000, TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SH_IR = 4'b1011,
		TAP_EX1_IR = 4'b1100, TAP_PA_IR = 4'b1101, TAP_EX2_IR = 4'b1110, TAP_UPD_IR = 4'b1111
	} dpac_tap_t;
endpackage

// [hw/dpac_sync.sv]
`timescale 1ns/10ps
module dpac_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Pins and filtered result.
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A bit moves only once two later stages agree, so one metastable sample never counts.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					level[i] <= RST_VAL[i];
				end else if (s2[i] == s3[i]) begin
					level[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule // dpac_sync

// [hw/dpac_top.sv]
`timescale 1ns/10ps
module dpac_top #(
	parameter int BSR_LEN = 8,
	parameter int TRACE_DIV = dpac_pkg::TRACE_DIV
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Straps from non-volatile settings.
	input wire logic [1:0] debug_port_select,
	input wire logic security_lock,
	// Firmware controls.
	input wire logic fw_jtag_disable,
	input wire logic fw_debug_enable,
	input wire logic fw_debug_disable,
	input wire logic fw_trace_single_wire,
	// Boundary-scan pins.
	input wire logic tck,
	input wire logic tms_in,
	input wire logic tdi,
	input wire logic test_reset_pin_n,
	output logic tdo,
	output logic tdo_oe,
	output logic tms_out,
	output logic tms_oe,
	// Serial-wire engine on the shared TMS pin.
	input wire logic swd_dout,
	input wire logic swd_doe,
	input wire logic swd_to_jtag,
	// Port status.
	output logic jtag_active,
	output logic pins_gpio,
	output logic debug_enable,
	output logic dev_reset_req,
	// Boundary cells.
	input wire logic [BSR_LEN-1:0] bsr_pin_in,
	output logic [BSR_LEN-1:0] bsr_pin_out,
	output logic bsr_drive,
	// Trace source and outputs.
	input wire logic trace_valid,
	input wire logic [7:0] trace_data,
	output logic trace_ready,
	output logic [3:0] parallel_trace_port,
	output logic parallel_trace_clk,
	output logic single_wire_trace_output
);
	logic [3:0] pins;
	logic tck_q;
	logic strap_taken;
	logic [1:0] port_sel;
	logic locked;
	logic swd_mode;
	dpac_pkg::dpac_tap_t tap;
	dpac_pkg::dpac_tap_t next_tap;
	logic [3:0] ir;
	logic [3:0] ir_sh;
	logic [31:0] id_sh;
	logic [BSR_LEN-1:0] bsr_sh;
	logic byp_sh;
	logic rst_sh;
	logic shift_bit;
	logic [7:0] tdiv;
	logic te;
	logic busy;
	logic [3:0] step;
	logic [9:0] tbuf;
	logic tsel;

	wire tck_s = pins[0];
	wire tms_s = pins[1];
	wire tdi_s = pins[2];
	wire trst_s = pins[3];
	wire tck_rise = tck_s && !tck_q;
	wire tck_fall = !tck_s && tck_q;
	wire port_on = strap_taken && !locked && port_sel != dpac_pkg::PSEL_OFF && !fw_jtag_disable;
	wire jtag_on = port_on && !swd_mode;
	wire trace_on = strap_taken && !locked && debug_enable;
	wire take = trace_ready && trace_valid;

	dpac_sync #(
		.WIDTH(4),
		.RST_VAL(dpac_pkg::PIN_RST)
	) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pin({test_reset_pin_n, tdi, tms_in, tck}),
		.level(pins)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Straps are caught on the first clock after release, never under reset itself.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strap_taken <= 1'b0;
			port_sel <= dpac_pkg::PSEL_OFF;
			locked <= 1'b1;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			port_sel <= debug_port_select;
			locked <= security_lock;
		end
	end

	// Serial-wire mode holds until the engine hands the port over to boundary scan.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			swd_mode <= 1'b0;
		end else if (!strap_taken) begin
			swd_mode <= debug_port_select == dpac_pkg::PSEL_SWD;
		end else if (swd_to_jtag) begin
			swd_mode <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tms_out <= 1'b0;
			tms_oe <= 1'b0;
			jtag_active <= 1'b0;
			pins_gpio <= 1'b1;
		end else begin
			tms_out <= swd_dout;
			tms_oe <= port_on && swd_mode && swd_doe;
			jtag_active <= jtag_on;
			pins_gpio <= !port_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic dpac_pkg::dpac_tap_t tap_step(input dpac_pkg::dpac_tap_t s, input logic m);
		case (s)
			dpac_pkg::TAP_RESET: tap_step = m ? dpac_pkg::TAP_RESET : dpac_pkg::TAP_IDLE;
			dpac_pkg::TAP_IDLE: tap_step = m ? dpac_pkg::TAP_SEL_DR : dpac_pkg::TAP_IDLE;
			dpac_pkg::TAP_SEL_DR: tap_step = m ? dpac_pkg::TAP_SEL_IR : dpac_pkg::TAP_CAP_DR;
			dpac_pkg::TAP_CAP_DR: tap_step = m ? dpac_pkg::TAP_EX1_DR : dpac_pkg::TAP_SH_DR;
			dpac_pkg::TAP_SH_DR: tap_step = m ? dpac_pkg::TAP_EX1_DR : dpac_pkg::TAP_SH_DR;
			dpac_pkg::TAP_EX1_DR: tap_step = m ? dpac_pkg::TAP_UPD_DR : dpac_pkg::TAP_PA_DR;
			dpac_pkg::TAP_PA_DR: tap_step = m ? dpac_pkg::TAP_EX2_DR : dpac_pkg::TAP_PA_DR;
			dpac_pkg::TAP_EX2_DR: tap_step = m ? dpac_pkg::TAP_UPD_DR : dpac_pkg::TAP_SH_DR;
			dpac_pkg::TAP_SEL_IR: tap_step = m ? dpac_pkg::TAP_RESET : dpac_pkg::TAP_CAP_IR;
			dpac_pkg::TAP_CAP_IR: tap_step = m ? dpac_pkg::TAP_EX1_IR : dpac_pkg::TAP_SH_IR;
			dpac_pkg::TAP_SH_IR: tap_step = m ? dpac_pkg::TAP_EX1_IR : dpac_pkg::TAP_SH_IR;
			dpac_pkg::TAP_EX1_IR: tap_step = m ? dpac_pkg::TAP_UPD_IR : dpac_pkg::TAP_PA_IR;
			dpac_pkg::TAP_PA_IR: tap_step = m ? dpac_pkg::TAP_EX2_IR : dpac_pkg::TAP_PA_IR;
			dpac_pkg::TAP_EX2_IR: tap_step = m ? dpac_pkg::TAP_UPD_IR : dpac_pkg::TAP_SH_IR;
			default: tap_step = m ? dpac_pkg::TAP_SEL_DR : dpac_pkg::TAP_IDLE;
		endcase
	endfunction

	always_comb begin
		next_tap = tap_step(tap, tms_s);
	end

	// The test reset pin only counts in five-wire mode; otherwise the host must walk TMS high.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tap <= dpac_pkg::TAP_RESET;
			tck_q <= 1'b0;
		end else begin
			tck_q <= tck_s;
			if (!jtag_on || (port_sel == dpac_pkg::PSEL_JTAG5 && !trst_s)) begin
				tap <= dpac_pkg::TAP_RESET;
			end else if (tck_rise) begin
				tap <= next_tap;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ir <= dpac_pkg::IR_IDCODE;
			ir_sh <= '0;
		end else if (tap == dpac_pkg::TAP_RESET) begin
			ir <= dpac_pkg::IR_IDCODE;
		end else if (tck_rise) begin
			case (tap)
				dpac_pkg::TAP_CAP_IR: ir_sh <= dpac_pkg::IR_CAPTURE;
				dpac_pkg::TAP_SH_IR: ir_sh <= {tdi_s, ir_sh[3:1]};
				dpac_pkg::TAP_UPD_IR: ir <= ir_sh;
				default: ir_sh <= ir_sh;
			endcase
		end
	end

	// Every data register shifts TDI in at the top, so devices chain on one connection.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			id_sh <= '0;
			bsr_sh <= '0;
			byp_sh <= 1'b0;
			rst_sh <= 1'b0;
		end else if (tck_rise && tap == dpac_pkg::TAP_CAP_DR) begin
			id_sh <= dpac_pkg::ID_CODE;
			bsr_sh <= bsr_pin_in;
			byp_sh <= 1'b0;
			rst_sh <= 1'b0;
		end else if (tck_rise && tap == dpac_pkg::TAP_SH_DR) begin
			case (ir)
				dpac_pkg::IR_IDCODE: id_sh <= {tdi_s, id_sh[31:1]};
				dpac_pkg::IR_EXTEST, dpac_pkg::IR_SAMPLE: bsr_sh <= {tdi_s, bsr_sh[BSR_LEN-1:1]};
				dpac_pkg::IR_DEVRST: rst_sh <= tdi_s;
				default: byp_sh <= tdi_s;
			endcase
		end
	end

	always_comb begin
		case (ir)
			dpac_pkg::IR_IDCODE: shift_bit = id_sh[0];
			dpac_pkg::IR_EXTEST, dpac_pkg::IR_SAMPLE: shift_bit = bsr_sh[0];
			dpac_pkg::IR_DEVRST: shift_bit = rst_sh;
			default: shift_bit = byp_sh;
		endcase
		if (tap == dpac_pkg::TAP_SH_IR) begin
			shift_bit = ir_sh[0];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
			bsr_pin_out <= '0;
			bsr_drive <= 1'b0;
			dev_reset_req <= 1'b0;
		end else begin
			if (tck_fall) begin
				tdo <= shift_bit;
				tdo_oe <= tap == dpac_pkg::TAP_SH_DR || tap == dpac_pkg::TAP_SH_IR;
			end
			if (tck_rise && tap == dpac_pkg::TAP_UPD_DR && ir == dpac_pkg::IR_EXTEST) begin
				bsr_pin_out <= bsr_sh;
			end
			bsr_drive <= jtag_on && ir == dpac_pkg::IR_EXTEST;
			dev_reset_req <= jtag_on && tck_rise && tap == dpac_pkg::TAP_UPD_DR
				&& ir == dpac_pkg::IR_DEVRST && rst_sh;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// No external path touches this flag; only firmware can turn debug on.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			debug_enable <= 1'b0;
		end else if (locked && strap_taken) begin
			debug_enable <= 1'b0;
		end else if (fw_debug_enable) begin
			debug_enable <= 1'b1;
		end else if (fw_debug_disable) begin
			debug_enable <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tdiv <= '0;
			te <= 1'b0;
		end else begin
			te <= tdiv == 8'(TRACE_DIV - 1);
			tdiv <= (tdiv == 8'(TRACE_DIV - 1)) ? 8'h00 : tdiv + 8'h01;
		end
	end

	// Parallel sends a byte as low then high nibble; single-wire frames it with start and stop.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			step <= '0;
			tbuf <= '1;
			tsel <= 1'b0;
			trace_ready <= 1'b0;
			parallel_trace_port <= '0;
			parallel_trace_clk <= 1'b0;
			single_wire_trace_output <= 1'b1;
		end else begin
			trace_ready <= trace_on && !busy && !take;
			if (take) begin
				busy <= 1'b1;
				step <= '0;
				tsel <= fw_trace_single_wire;
				tbuf <= {1'b1, trace_data, 1'b0};
			end else if (busy && te) begin
				step <= step + 4'h1;
				if (tsel) begin
					single_wire_trace_output <= tbuf[0];
					tbuf <= {1'b1, tbuf[9:1]};
					busy <= step != dpac_pkg::SER_STEPS - 4'h1;
				end else begin
					parallel_trace_port <= step[0] ? tbuf[8:5] : tbuf[4:1];
					parallel_trace_clk <= !parallel_trace_clk;
					busy <= step != dpac_pkg::PAR_STEPS - 4'h1;
				end
			end else if (!busy) begin
				single_wire_trace_output <= 1'b1;
			end
		end
	end
endmodule // dpac_top

// [tb/dpac_top_chk.sv]
`timescale 1ns/10ps
module dpac_top_chk #(
	parameter int BSR_LEN = 8,
	parameter int TRACE_DIV = 4
) (
	// Clock, reset and straps.
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] debug_port_select,
	input wire logic security_lock,
	// Firmware side and the serial-wire output enable.
	input wire logic fw_debug_enable,
	input wire logic fw_debug_disable,
	input wire logic fw_trace_single_wire,
	input wire logic swd_doe,
	// Watched outputs and the trace valid input.
	input wire logic tdo_oe,
	input wire logic tms_oe,
	input wire logic jtag_active,
	input wire logic debug_enable,
	input wire logic dev_reset_req,
	input wire logic trace_valid,
	input wire logic trace_ready,
	input wire logic parallel_trace_clk,
	input wire logic single_wire_trace_output
);
	// Straps are copied at the first edge, so a strap moved later cannot skew the checks.
	logic [1:0] age;
	logic lock_q;
	logic [1:0] port_sel_q;
	logic live;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			age <= 2'h0;
			lock_q <= 1'b0;
			port_sel_q <= 2'h0;
		end else begin
			if (age != 2'h3)
				age <= age + 2'h1;
			if (age == 2'h0) begin
				lock_q <= security_lock;
				port_sel_q <= debug_port_select;
			end
		end
	end
	assign live = age == 2'h3;
	////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_lock_shut: assert property (live && lock_q |-> !tdo_oe && !jtag_active && !debug_enable)
		else $error("locked part shows port activity");
	chk_off_quiet: assert property (live && port_sel_q == dpac_pkg::PSEL_OFF |-> !jtag_active && !dev_reset_req)
		else $error("disabled ports still act");
	chk_rst_single: assert property (dev_reset_req |=> !dev_reset_req)
		else $error("reset request longer than one cycle");
	chk_tms_mode: assert property (live && tms_oe |-> port_sel_q == dpac_pkg::PSEL_SWD && $past(swd_doe))
		else $error("tms driven outside serial-wire mode");
	chk_dbg_cause: assert property ($rose(debug_enable) |-> $past(fw_debug_enable))
		else $error("debug enabled without firmware");
	chk_dbg_drop: assert property (live && fw_debug_disable && !fw_debug_enable |=> !debug_enable)
		else $error("debug not disabled");
	chk_trace_hold: assert property (trace_valid && trace_ready |=> !trace_ready [*4])
		else $error("trace taken during a frame");
	chk_swo_start: assert property (live && trace_valid && trace_ready && fw_trace_single_wire
		|-> ##[1:12] !single_wire_trace_output)
		else $error("no start bit on single wire");
	chk_par_clock: assert property (live && trace_valid && trace_ready && !fw_trace_single_wire
		|-> ##[1:12] $changed(parallel_trace_clk))
		else $error("parallel trace clock idle");
	cover property (dev_reset_req);
	cover property (tms_oe);
	cover property (trace_valid && trace_ready);
endmodule // dpac_top_chk

bind dpac_top dpac_top_chk #(.BSR_LEN(BSR_LEN), .TRACE_DIV(TRACE_DIV)) u_chk (
	.mclk, .nrst, .debug_port_select, .security_lock, .fw_debug_enable, .fw_debug_disable,
	.fw_trace_single_wire, .swd_doe, .tdo_oe, .tms_oe, .jtag_active, .debug_enable, .dev_reset_req,
	.trace_valid, .trace_ready, .parallel_trace_clk, .single_wire_trace_output
);

// [tb/dpac_host_model.sv]
`timescale 1ns/10ps
module dpac_host_model (
	// Link pins.
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end
	// A 5 MHz link stays under 12 MHz and a fifth of mclk; tdo is read late in the high phase
	// because the block answers only after its pin synchroniser.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#100 tck = 1'b1;
		#100 q = tdo;
		tck = 1'b0;
	endtask
	task automatic tap_reset();
		logic q;
		repeat (5)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic pull_trst();
		logic q;
		trst_n = 1'b0;
		#400 trst_n = 1'b1;
		step(1'b0, 1'b0, q);
	endtask
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule // dpac_host_model

// [tb/dpac_top_tb.sv]
`timescale 1ns/10ps
module dpac_top_tb;
	logic mclk = 1'b0, nrst = 1'b0, lock = 1'b0, fw_dis = 1'b0, fw_en = 1'b0, fw_off = 1'b0, fw_sw = 1'b0;
	logic swd_dout = 1'b0, swd_doe = 1'b0, swd_to_jtag = 1'b0, tvalid = 1'b0;
	logic [1:0] port_sel = 2'h0;
	logic [7:0] bsr_in = 8'h00, tdata = 8'h00, bsr_out;
	logic tck, tms, tdi, trst_n, tdo, tdo_oe, tms_out, tms_oe, jtag_active, pins_gpio, debug_enable;
	logic dev_reset_req, bsr_drive, tready, par_clk, swo;
	logic [3:0] par;
	logic [31:0] q;
	int n_mismatch = 0, total_checks = 0, n_pulse = 0, n_oe = 0;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		if (dev_reset_req === 1'h1)
			n_pulse++;
		if (tdo_oe === 1'h1)
			n_oe++;
	end
	dpac_top #(.BSR_LEN(8), .TRACE_DIV(4)) u_dut (
		.mclk, .nrst, .debug_port_select(port_sel), .security_lock(lock), .fw_jtag_disable(fw_dis),
		.fw_debug_enable(fw_en), .fw_debug_disable(fw_off), .fw_trace_single_wire(fw_sw), .tck, .tms_in(tms),
		.tdi, .test_reset_pin_n(trst_n), .tdo, .tdo_oe, .tms_out, .tms_oe, .swd_dout, .swd_doe, .swd_to_jtag,
		.jtag_active, .pins_gpio, .debug_enable, .dev_reset_req, .bsr_pin_in(bsr_in), .bsr_pin_out(bsr_out),
		.bsr_drive, .trace_valid(tvalid), .trace_data(tdata), .trace_ready(tready), .parallel_trace_port(par),
		.parallel_trace_clk(par_clk), .single_wire_trace_output(swo)
	);
	dpac_host_model u_host (.tck, .tms, .tdi, .trst_n, .tdo);
	////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tmo(input int i);
		if (i >= 50)
			chk("wait bound", 32'h0, 32'h1);
		if (i >= 50)
			end_of_test();
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(3);
	endtask
	task automatic boot(input logic [1:0] d, input logic l);
		nrst = 1'b0;
		port_sel = d;
		lock = l;
		cyc(12);
		nrst = 1'b1;
		cyc(8);
		n_oe = 0;
	endtask
	////////////////
	task automatic t_scan();
		chk("jtag_active", 1'h1, jtag_active);
		u_host.tap_reset();
		u_host.scan(1'b0, 32, 32'h0, q);
		chk("idcode", dpac_pkg::ID_CODE, q);
		u_host.scan(1'b1, 4, {28'h0, dpac_pkg::IR_BYPASS}, q);
		chk("ir capture", {28'h0, dpac_pkg::IR_CAPTURE}, q);
		u_host.scan(1'b0, 8, 32'h0000_00B6, q);
		chk("bypass", 32'h0000_006C, q);
		bsr_in = 8'hA5;
		u_host.scan(1'b1, 4, {28'h0, dpac_pkg::IR_SAMPLE}, q);
		u_host.scan(1'b0, 8, 32'h0000_003C, q);
		chk("bsr capture", 32'h0000_00A5, q);
		u_host.scan(1'b1, 4, {28'h0, dpac_pkg::IR_EXTEST}, q);
		u_host.scan(1'b0, 8, 32'h0000_003C, q);
		cyc(2);
		chk("bsr out", 9'h13C, {bsr_drive, bsr_out});
	endtask
	task automatic t_devrst(input logic [31:0] exp);
		u_host.tap_reset();
		n_pulse = 0;
		u_host.scan(1'b1, 4, {28'h0, dpac_pkg::IR_DEVRST}, q);
		u_host.scan(1'b0, 1, 32'h0000_0001, q);
		cyc(4);
		chk("reset pulses", exp, n_pulse);
	endtask
	task automatic t_debug();
		chk("debug_enable", 1'h0, debug_enable);
		u_host.scan(1'b0, 32, 32'h0, q);
		chk("debug_enable", 1'h0, debug_enable);
		pulse(fw_en);
		chk("debug_enable", 1'h1, debug_enable);
		pulse(fw_off);
		chk("debug_enable", 1'h0, debug_enable);
	endtask
	task automatic t_fwdis();
		fw_dis = 1'b1;
		cyc(6);
		n_oe = 0;
		u_host.scan(1'b0, 8, 32'h0, q);
		chk("pins_gpio", 32'h1, {31'h0, pins_gpio});
		chk("tdo_oe cycles", 32'h0, n_oe);
		fw_dis = 1'b0;
		cyc(6);
		chk("jtag_active", 1'h1, jtag_active);
	endtask
	task automatic t_trace(input logic sw);
		logic [9:0] got;
		logic old;
		int i;
		got = '0;
		// Trace only runs while firmware holds debug on, and the debug scenario left it off.
		pulse(fw_en);
		fw_sw = sw;
		tvalid = 1'b1;
		tdata = 8'h6B;
		for (i = 0; i < 50 && tready !== 1'h1; i++)
			cyc(1);
		tmo(i);
		old = sw ? swo : par_clk;
		cyc(1);
		tvalid = 1'b0;
		for (int b = 0; b < (sw ? 10 : 2); b++) begin
			for (i = 0; i < 50 && (sw ? b == 0 && swo !== 1'h0 : par_clk === old); i++)
				cyc(1);
			tmo(i);
			if (sw && b == 0)
				cyc(2);
			if (sw)
				got[b] = swo;
			else
				got[b*4+:4] = par;
			old = par_clk;
			if (sw)
				cyc(4);
		end
		chk("trace frame", sw ? {1'h1, 8'h6B, 1'h0} : 10'h06B, got);
		cyc(12);
	endtask
	task automatic t_shut(input logic [1:0] d, input logic l);
		boot(d, l);
		pulse(fw_en);
		t_devrst(32'h0);
		chk("port status", {2'h1, !l}, {jtag_active, pins_gpio, debug_enable});
		chk("tdo_oe cycles", 32'h0, n_oe);
	endtask
	task automatic t_swd();
		boot(dpac_pkg::PSEL_SWD, 1'b0);
		swd_doe = 1'b1;
		swd_dout = 1'b1;
		cyc(3);
		chk("tms drive", 3'h3, {jtag_active, tms_oe, tms_out});
		pulse(swd_to_jtag);
		chk("tms after switch", 2'h2, {jtag_active, tms_oe});
		swd_doe = 1'b0;
	endtask
	initial begin
		boot(dpac_pkg::PSEL_JTAG4, 1'b0);
		t_scan();
		t_devrst(32'h1);
		t_debug();
		t_fwdis();
		t_trace(1'b0);
		t_trace(1'b1);
		t_shut(dpac_pkg::PSEL_OFF, 1'b0);
		t_shut(dpac_pkg::PSEL_JTAG4, 1'b1);
		t_swd();
		boot(dpac_pkg::PSEL_JTAG5, 1'b0);
		u_host.tap_reset();
		u_host.scan(1'b1, 4, {28'h0, dpac_pkg::IR_BYPASS}, q);
		u_host.pull_trst();
		u_host.scan(1'b0, 32, 32'h0, q);
		chk("idcode after pin reset", dpac_pkg::ID_CODE, q);
		end_of_test();
	end
endmodule // dpac_top_tb
